//--- src/ces_pkg.sv
// Purpose: constants and types for the cpu exception sequencer
// Assumes: advanced or normal vector layout selected by a port
// Notes:   vector numbers of sources outside this block kept for reference
package ces_pkg;
    localparam logic [6:0] VEC_RESET     = 7'h00;
    localparam logic [6:0] VEC_TRACE     = 7'h05;
    localparam logic [6:0] VEC_DIRECT    = 7'h06;
    localparam logic [6:0] VEC_NMI       = 7'h07;
    localparam logic [6:0] VEC_TRAP0     = 7'h08;
    localparam logic [6:0] VEC_TRAP3     = 7'h0b;
    localparam logic [6:0] VEC_IRQ0      = 7'h10;
    localparam logic [6:0] VEC_INTERNAL0 = 7'h18;
    localparam logic [6:0] VEC_LAST      = 7'h7f;
    localparam logic [1:0] INTM_MODE0    = 2'h0;
    localparam logic [1:0] INTM_MODE2    = 2'h2;
    localparam int         CCR_I_BIT     = 7;
    localparam int         CCR_UI_BIT    = 6;
    localparam int         EXR_T_BIT     = 7;
    localparam logic [7:0] CCR_INIT      = 8'h80;
    localparam logic [7:0] EXR_INIT      = 8'h07;
    localparam logic [7:0] MSTP_A_INIT   = 8'h3f;
    localparam logic [7:0] MSTP_BC_INIT  = 8'hff;
    localparam logic [2:0] SEL_CCR       = 3'h0;
    localparam logic [2:0] SEL_EXR       = 3'h1;
    localparam logic [2:0] SEL_INTM      = 3'h2;
    localparam logic [2:0] SEL_MSTP_A    = 3'h3;
    localparam logic [2:0] SEL_MSTP_B    = 3'h4;
    localparam logic [2:0] SEL_MSTP_C    = 3'h5;

    typedef enum logic [1:0] {ST_RST_VEC, ST_RUN, ST_EXC} ces_state_t;

    // slot is two bytes in normal mode, four in advanced mode
    function automatic logic [15:0] ces_vec_addr(input logic [6:0] vec,
                                                 input logic       normal);
        ces_vec_addr = normal ? {8'h00, vec, 1'b0} : {7'h00, vec, 2'b00};
    endfunction
endpackage

//--- src/ces_top.sv
// Purpose: exception sequencer: ranks, vectors and starts cpu exceptions
// Assumes: instruction strobes and interrupt requests are on clk_sys
// Notes:   rstn is the asynchronous reset, released via two flops
module ces_top
    import ces_pkg::*;
(
    // clock and reset pin
    input  wire logic       clk_sys,
    input  wire logic       rstn,
    // reset sources and layout
    input  wire logic       wdt_ovf,
    input  wire logic       normal_mode,
    // instruction sequencer
    input  wire logic       instr_done,
    input  wire logic       return_from_exception,
    input  wire logic       and_control_instr,
    input  wire logic       or_control_instr,
    input  wire logic       xor_control_instr,
    input  wire logic       load_control_instr,
    input  wire logic       trap_instr,
    input  wire logic [1:0] trap_num,
    input  wire logic       sleep_direct,
    // interrupt controller
    input  wire logic       irq_req,
    input  wire logic [6:0] irq_vec,
    input  wire logic [2:0] irq_level,
    output logic            irq_ack_reg,
    // control register writes
    input  wire logic       ctrl_wr,
    input  wire logic [2:0] ctrl_sel,
    input  wire logic [7:0] ctrl_wdata,
    // exception start
    output logic            exc_start_reg,
    output logic [6:0]      exc_vec_reg,
    output logic [15:0]     vec_addr_reg,
    output logic            fetch_long_reg,
    output logic            stack_push_reg,
    output logic [7:0]      stacked_ccr_reg,
    output logic [7:0]      stacked_exr_reg,
    // state
    output logic            in_reset_reg,
    output logic [7:0]      condition_code_reg,
    output logic [7:0]      extended_control_reg,
    output logic [1:0]      intm_reg,
    output logic [7:0]      module_stop_ctrl_a,
    output logic [7:0]      module_stop_ctrl_b,
    output logic [7:0]      module_stop_ctrl_c
);
    logic       rst_s1_reg, sys_rstn;
    ces_state_t state_reg, state_next;
    logic       bnd_reg, bnd_next, skip_irq_reg, skip_irq_next;
    logic       first_blk_reg, first_blk_next;
    logic       trace_pend_reg, trace_pend_next;
    logic       direct_pend_reg, direct_pend_next;
    logic       trap_pend_reg, trap_pend_next;
    logic [1:0] trap_num_reg, trap_num_next;
    logic       irq_ack_next, exc_start_next, fetch_long_next;
    logic       stack_push_next, in_reset_next;
    logic [6:0] exc_vec_next, take_vec;
    logic [15:0] vec_addr_next;
    logic [7:0] stacked_ccr_next, stacked_exr_next, ccr_next, exr_next;
    logic [7:0] mstp_a_next, mstp_b_next, mstp_c_next;
    logic [1:0] intm_next;
    logic       take, take_irq, trace_on, ctrl_instr;
    // first flop only feeds the second; design resets off the second
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            rst_s1_reg <= 1'b0;
            sys_rstn   <= 1'b0;
        end else begin
            rst_s1_reg <= 1'b1;
            sys_rstn   <= rst_s1_reg;
        end
    end
    assign trace_on   = extended_control_reg[EXR_T_BIT]
                        && (intm_reg == INTM_MODE2);
    assign ctrl_instr = and_control_instr | or_control_instr
                        | xor_control_instr | load_control_instr;
    always_comb begin
        state_next       = state_reg;
        bnd_next         = 1'b0;
        skip_irq_next    = skip_irq_reg;
        first_blk_next   = first_blk_reg;
        trace_pend_next  = trace_pend_reg;
        direct_pend_next = direct_pend_reg;
        trap_pend_next   = trap_pend_reg;
        trap_num_next    = trap_num_reg;
        irq_ack_next     = 1'b0;
        exc_start_next   = 1'b0;
        stack_push_next  = 1'b0;
        fetch_long_next  = fetch_long_reg;
        exc_vec_next     = exc_vec_reg;
        vec_addr_next    = vec_addr_reg;
        stacked_ccr_next = stacked_ccr_reg;
        stacked_exr_next = stacked_exr_reg;
        in_reset_next    = in_reset_reg;
        ccr_next         = condition_code_reg;
        exr_next         = extended_control_reg;
        intm_next        = intm_reg;
        mstp_a_next      = module_stop_ctrl_a;
        mstp_b_next      = module_stop_ctrl_b;
        mstp_c_next      = module_stop_ctrl_c;
        take             = 1'b0;
        take_irq         = 1'b0;
        take_vec         = VEC_RESET;
        if (ctrl_wr) begin
            case (ctrl_sel)
                SEL_CCR:    ccr_next    = ctrl_wdata;
                SEL_EXR:    exr_next    = ctrl_wdata;
                SEL_INTM:   intm_next   = ctrl_wdata[1:0];
                SEL_MSTP_A: mstp_a_next = ctrl_wdata;
                SEL_MSTP_B: mstp_b_next = ctrl_wdata;
                SEL_MSTP_C: mstp_c_next = ctrl_wdata;
                default:    ccr_next    = condition_code_reg;
            endcase
        end
        case (state_reg)
            ST_RST_VEC: begin
                exc_start_next  = 1'b1;
                exc_vec_next    = VEC_RESET;
                vec_addr_next   = ces_vec_addr(VEC_RESET, normal_mode);
                fetch_long_next = ~normal_mode;
                in_reset_next   = 1'b0;
                first_blk_next  = 1'b1;
                state_next      = ST_RUN;
            end
            ST_RUN: begin
                if (bnd_reg) begin
                    // earlier sources win; the rest keep their pending bit
                    if (trace_pend_reg) begin
                        take            = 1'b1;
                        take_vec        = VEC_TRACE;
                        trace_pend_next = 1'b0;
                    end else if (direct_pend_reg) begin
                        take             = 1'b1;
                        take_vec         = VEC_DIRECT;
                        direct_pend_next = 1'b0;
                    end else if (irq_req && !skip_irq_reg) begin
                        take     = 1'b1;
                        take_irq = 1'b1;
                        take_vec = irq_vec;
                    end else if (trap_pend_reg) begin
                        take           = 1'b1;
                        take_vec       = VEC_TRAP0
                                         + {5'h00, trap_num_reg};
                        trap_pend_next = 1'b0;
                    end
                end
            end
            ST_EXC: begin
                // end of exception handling is a boundary too
                bnd_next      = 1'b1;
                skip_irq_next = 1'b0;
                state_next    = ST_RUN;
            end
            default: state_next = ST_RST_VEC;
        endcase
        if (take) begin
            exc_start_next   = 1'b1;
            exc_vec_next     = take_vec;
            vec_addr_next    = ces_vec_addr(take_vec, normal_mode);
            fetch_long_next  = ~normal_mode;
            stack_push_next  = 1'b1;
            stacked_ccr_next = condition_code_reg;
            stacked_exr_next = extended_control_reg;
            irq_ack_next     = take_irq;
            ccr_next[CCR_I_BIT] = 1'b1;
            exr_next[EXR_T_BIT] = 1'b0;
            if (take_irq && intm_reg == INTM_MODE2) begin
                exr_next[2:0] = irq_level;
            end
            state_next = ST_EXC;
        end
        // new events after the accept logic so a set beats a clear
        if (instr_done) begin
            bnd_next       = 1'b1;
            skip_irq_next  = ctrl_instr | first_blk_reg;
            first_blk_next = 1'b0;
            if (trace_on && !return_from_exception) begin
                trace_pend_next = 1'b1;
            end
        end
        if (trap_instr) begin
            trap_pend_next = 1'b1;
            trap_num_next  = trap_num;
        end
        if (sleep_direct) begin
            direct_pend_next = 1'b1;
        end
        if (wdt_ovf) begin
            // watchdog restarts the whole reset sequence
            state_next       = ST_RST_VEC;
            in_reset_next    = 1'b1;
            trace_pend_next  = 1'b0;
            direct_pend_next = 1'b0;
            trap_pend_next   = 1'b0;
            bnd_next         = 1'b0;
            ccr_next         = CCR_INIT;
            exr_next         = EXR_INIT;
            intm_next        = INTM_MODE0;
            mstp_a_next      = MSTP_A_INIT;
            mstp_b_next      = MSTP_BC_INIT;
            mstp_c_next      = MSTP_BC_INIT;
        end
    end
    always_ff @(posedge clk_sys or negedge sys_rstn) begin
        if (!sys_rstn) begin
            state_reg            <= ST_RST_VEC;
            bnd_reg              <= 1'b0;
            skip_irq_reg         <= 1'b1;
            first_blk_reg        <= 1'b1;
            trace_pend_reg       <= 1'b0;
            direct_pend_reg      <= 1'b0;
            trap_pend_reg        <= 1'b0;
            trap_num_reg         <= 2'h0;
            irq_ack_reg          <= 1'b0;
            exc_start_reg        <= 1'b0;
            exc_vec_reg          <= VEC_RESET;
            vec_addr_reg         <= 16'h0000;
            fetch_long_reg       <= 1'b0;
            stack_push_reg       <= 1'b0;
            stacked_ccr_reg      <= 8'h00;
            stacked_exr_reg      <= 8'h00;
            in_reset_reg         <= 1'b1;
            condition_code_reg   <= CCR_INIT;
            extended_control_reg <= EXR_INIT;
            intm_reg             <= INTM_MODE0;
            module_stop_ctrl_a   <= MSTP_A_INIT;
            module_stop_ctrl_b   <= MSTP_BC_INIT;
            module_stop_ctrl_c   <= MSTP_BC_INIT;
        end else begin
            state_reg            <= state_next;
            bnd_reg              <= bnd_next;
            skip_irq_reg         <= skip_irq_next;
            first_blk_reg        <= first_blk_next;
            trace_pend_reg       <= trace_pend_next;
            direct_pend_reg      <= direct_pend_next;
            trap_pend_reg        <= trap_pend_next;
            trap_num_reg         <= trap_num_next;
            irq_ack_reg          <= irq_ack_next;
            exc_start_reg        <= exc_start_next;
            exc_vec_reg          <= exc_vec_next;
            vec_addr_reg         <= vec_addr_next;
            fetch_long_reg       <= fetch_long_next;
            stack_push_reg       <= stack_push_next;
            stacked_ccr_reg      <= stacked_ccr_next;
            stacked_exr_reg      <= stacked_exr_next;
            in_reset_reg         <= in_reset_next;
            condition_code_reg   <= ccr_next;
            extended_control_reg <= exr_next;
            intm_reg             <= intm_next;
            module_stop_ctrl_a   <= mstp_a_next;
            module_stop_ctrl_b   <= mstp_b_next;
            module_stop_ctrl_c   <= mstp_c_next;
        end
    end
    property p_prio;
        @(posedge clk_sys) disable iff (!sys_rstn)
        (state_reg == ST_RUN && bnd_reg && trace_pend_reg && !wdt_ovf)
            |=> exc_start_reg && exc_vec_reg == VEC_TRACE;
    endproperty
    a_prio: assert property (p_prio) else $error("trace not first");
    property p_wdt;
        @(posedge clk_sys) disable iff (!sys_rstn)
        wdt_ovf |=> in_reset_reg
            ##1 (exc_start_reg && exc_vec_reg == VEC_RESET);
    endproperty
    a_wdt: assert property (p_wdt) else $error("no reset after wdt");
    property p_trace_set;
        @(posedge clk_sys) disable iff (!sys_rstn)
        (instr_done && trace_on && !return_from_exception && !wdt_ovf)
            |=> trace_pend_reg;
    endproperty
    a_trace_set: assert property (p_trace_set)
        else $error("trace missed");
    property p_ctrl_skip;
        @(posedge clk_sys) disable iff (!sys_rstn)
        (instr_done && ctrl_instr) |-> ##2 !irq_ack_reg;
    endproperty
    a_ctrl_skip: assert property (p_ctrl_skip)
        else $error("irq after ctrl");
    property p_addr;
        @(posedge clk_sys) disable iff (!sys_rstn)
        (exc_start_reg && fetch_long_reg)
            |-> vec_addr_reg == {7'h00, exc_vec_reg, 2'b00};
    endproperty
    a_addr: assert property (p_addr) else $error("bad vector addr");
    property p_trace_fx;
        @(posedge clk_sys) disable iff (!sys_rstn)
        (exc_start_reg && exc_vec_reg == VEC_TRACE)
            |-> condition_code_reg[CCR_I_BIT]
                && !extended_control_reg[EXR_T_BIT]
                && stacked_exr_reg[EXR_T_BIT];
    endproperty
    a_trace_fx: assert property (p_trace_fx)
        else $error("trace effects");
    property p_rte;
        @(posedge clk_sys) disable iff (!sys_rstn)
        (instr_done && return_from_exception && !trace_pend_reg)
            |=> !trace_pend_reg;
    endproperty
    a_rte: assert property (p_rte) else $error("trace after return");
    property p_mode0;
        @(posedge clk_sys) disable iff (!sys_rstn)
        (intm_reg == INTM_MODE0 && !trace_pend_reg) |=> !trace_pend_reg;
    endproperty
    a_mode0: assert property (p_mode0) else $error("mode 0 trace");
    property p_rst_fx;
        @(posedge clk_sys) disable iff (!sys_rstn)
        $fell(in_reset_reg) |-> exc_start_reg && intm_reg == INTM_MODE0
            && module_stop_ctrl_a == MSTP_A_INIT && !stack_push_reg;
    endproperty
    a_rst_fx: assert property (p_rst_fx) else $error("bad reset");
endmodule

//--- testbench/ces_intc_model.sv
// Purpose: interrupt controller seen from the exception sequencer
// Assumes: bench raises one request at a time with a one-cycle strobe
// Notes:   vector lines churn while idle so stale values never match
module ces_intc_model (
    // clock and reset
    input  wire logic       clk_sys,
    input  wire logic       rstn,
    // bench command
    input  wire logic       raise,
    input  wire logic [6:0] raise_vec,
    input  wire logic [2:0] raise_level,
    // towards the sequencer
    input  wire logic       irq_ack_reg,
    output logic            irq_req,
    output logic [6:0]      irq_vec,
    output logic [2:0]      irq_level
);
    timeunit 1ns;
    timeprecision 1ps;

    // request held as a level until acknowledged, never dropped early
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            irq_req   <= 1'b0;
            irq_vec   <= 7'h55;
            irq_level <= 3'h2;
        end else if (raise) begin
            irq_req   <= 1'b1;
            irq_vec   <= raise_vec;
            irq_level <= raise_level;
        end else if (irq_ack_reg) begin
            irq_req <= 1'b0;
        end else if (!irq_req) begin
            irq_vec   <= ~irq_vec;
            irq_level <= ~irq_level;
        end
    end
endmodule

//--- testbench/tb_top.sv
// Purpose: self-checking bench for the exception sequencer
// Assumes: inputs change 1 ns after the rising edge
// Notes:   power-up reset is only 12 cycles; mid-run reset holds 20 cycles
module tb_top
    import ces_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk_sys, rstn, wdt_ovf, normal_mode, instr_done;
    logic return_from_exception, and_control_instr, or_control_instr;
    logic xor_control_instr, load_control_instr, trap_instr, sleep_direct;
    logic [1:0] trap_num;
    logic irq_req, irq_ack_reg, ctrl_wr, raise;
    logic [6:0] irq_vec, raise_vec, exc_vec_reg;
    logic [2:0] irq_level, raise_level, ctrl_sel;
    logic [7:0] ctrl_wdata, stacked_ccr_reg, stacked_exr_reg;
    logic exc_start_reg, fetch_long_reg, stack_push_reg, in_reset_reg;
    logic [15:0] vec_addr_reg;
    logic [7:0] condition_code_reg, extended_control_reg;
    logic [7:0] module_stop_ctrl_a, module_stop_ctrl_b, module_stop_ctrl_c;
    logic [1:0] intm_reg;
    int error_cnt = 0;
    int comparisons = 0;

    ces_top ces_top_i (.clk_sys(clk_sys), .rstn(rstn), .wdt_ovf(wdt_ovf),
        .normal_mode(normal_mode), .instr_done(instr_done),
        .return_from_exception(return_from_exception),
        .and_control_instr(and_control_instr),
        .or_control_instr(or_control_instr),
        .xor_control_instr(xor_control_instr),
        .load_control_instr(load_control_instr), .trap_instr(trap_instr),
        .trap_num(trap_num), .sleep_direct(sleep_direct),
        .irq_req(irq_req), .irq_vec(irq_vec), .irq_level(irq_level),
        .irq_ack_reg(irq_ack_reg), .ctrl_wr(ctrl_wr), .ctrl_sel(ctrl_sel),
        .ctrl_wdata(ctrl_wdata), .exc_start_reg(exc_start_reg),
        .exc_vec_reg(exc_vec_reg), .vec_addr_reg(vec_addr_reg),
        .fetch_long_reg(fetch_long_reg), .stack_push_reg(stack_push_reg),
        .stacked_ccr_reg(stacked_ccr_reg),
        .stacked_exr_reg(stacked_exr_reg), .in_reset_reg(in_reset_reg),
        .condition_code_reg(condition_code_reg),
        .extended_control_reg(extended_control_reg), .intm_reg(intm_reg),
        .module_stop_ctrl_a(module_stop_ctrl_a),
        .module_stop_ctrl_b(module_stop_ctrl_b),
        .module_stop_ctrl_c(module_stop_ctrl_c));

    ces_intc_model ces_intc_model_i (.clk_sys(clk_sys), .rstn(rstn),
        .raise(raise), .raise_vec(raise_vec), .raise_level(raise_level),
        .irq_ack_reg(irq_ack_reg), .irq_req(irq_req), .irq_vec(irq_vec),
        .irq_level(irq_level));

    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end

    task automatic step;
        @(posedge clk_sys);
        #1;
    endtask

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED t=%0t seen %h exp %h", $time, seen, exp);
        end
    endtask

    task automatic print_verdict;
        $display("errors %0d comparisons %0d", error_cnt, comparisons);
        if (error_cnt == 0 && comparisons > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // strobes are lowered a full cycle before the next task may raise them
    task automatic boundary(input logic [4:0] q);
        {return_from_exception, and_control_instr, or_control_instr,
         xor_control_instr, load_control_instr} = q;
        instr_done = 1'b1;
        step;
        instr_done = 1'b0;
        {return_from_exception, and_control_instr, or_control_instr,
         xor_control_instr, load_control_instr} = 5'h0;
        step;
    endtask

    task automatic evt(input logic t, input logic d, input logic [1:0] n);
        trap_num = n;
        trap_instr = t;
        sleep_direct = d;
        step;
        trap_instr = 1'b0;
        sleep_direct = 1'b0;
        step;
    endtask

    task automatic ctrl(input logic [2:0] sel, input logic [7:0] data);
        ctrl_sel = sel;
        ctrl_wdata = data;
        ctrl_wr = 1'b1;
        step;
        ctrl_wr = 1'b0;
        step;
    endtask

    task automatic irq(input logic [6:0] v, input logic [2:0] l);
        raise_vec = v;
        raise_level = l;
        raise = 1'b1;
        step;
        raise = 1'b0;
        step;
    endtask

    task automatic expect_none(input int n);
        repeat (n) begin
            check(16'(exc_start_reg), 16'h0);
            step;
        end
    endtask

    task automatic wait_start(input logic [6:0] v, input logic push,
                              input logic ack);
        int n;
        logic [15:0] a;
        n = 0;
        a = normal_mode ? {8'h00, v, 1'b0} : {7'h00, v, 2'b00};
        while (exc_start_reg !== 1'b1 && n < 10) begin
            step;
            n++;
        end
        check({exc_start_reg, stack_push_reg, irq_ack_reg, fetch_long_reg,
               5'h0, exc_vec_reg},
              {1'b1, push, ack, ~normal_mode, 5'h0, v});
        check(vec_addr_reg, a);
        step;
    endtask

    task automatic reset_vals;
        check({in_reset_reg, 5'h0, intm_reg, condition_code_reg},
              {1'b1, 5'h0, INTM_MODE0, CCR_INIT});
        check({extended_control_reg, module_stop_ctrl_a},
              {EXR_INIT, MSTP_A_INIT});
        check({module_stop_ctrl_b, module_stop_ctrl_c},
              {MSTP_BC_INIT, MSTP_BC_INIT});
    endtask

    initial begin
        {rstn, wdt_ovf, normal_mode} = 3'h0;
        {instr_done, trap_instr, sleep_direct} = 3'h0;
        {return_from_exception, and_control_instr, or_control_instr} = 3'h0;
        {xor_control_instr, load_control_instr, ctrl_wr, raise} = 4'h0;
        {trap_num, raise_vec, raise_level, ctrl_sel, ctrl_wdata} = 23'h0;
        repeat (12) step;
        reset_vals;
        rstn = 1'b1;
        wait_start(VEC_RESET, 1'b0, 1'b0);
        check(16'(in_reset_reg), 16'h0);
        irq(VEC_NMI, 3'h7);
        boundary(5'h0);
        expect_none(4);
        for (int i = 0; i < 4; i++) begin
            boundary(5'h1 << i);
            expect_none(4);
        end
        boundary(5'h0);
        wait_start(VEC_NMI, 1'b1, 1'b1);
        ctrl(SEL_INTM, 8'h02);
        ctrl(SEL_CCR, 8'h40);
        ctrl(SEL_EXR, 8'h83);
        boundary(5'h0);
        wait_start(VEC_TRACE, 1'b1, 1'b0);
        check({condition_code_reg, extended_control_reg}, 16'hc003);
        check({stacked_ccr_reg, stacked_exr_reg}, 16'h4083);
        ctrl(SEL_EXR, 8'h83);
        boundary(5'h10);
        expect_none(4);
        ctrl(SEL_INTM, 8'h00);
        boundary(5'h0);
        expect_none(4);
        // all four sources at one boundary, taken one per exception end
        ctrl(SEL_INTM, 8'h02);
        irq(7'h15, 3'h4);
        evt(1'b1, 1'b1, 2'h1);
        boundary(5'h0);
        wait_start(VEC_TRACE, 1'b1, 1'b0);
        wait_start(VEC_DIRECT, 1'b1, 1'b0);
        wait_start(7'h15, 1'b1, 1'b1);
        check(16'(extended_control_reg), 16'h0004);
        wait_start(VEC_TRAP0 + 7'h1, 1'b1, 1'b0);
        normal_mode = 1'b1;
        for (int i = 0; i < 4; i++) begin
            ctrl(SEL_CCR, {i[0], 7'h40});
            evt(1'b1, 1'b0, 2'(i));
            boundary(5'h0);
            wait_start(VEC_TRAP0 + 7'(i), 1'b1, 1'b0);
            check({stacked_ccr_reg, condition_code_reg},
                  {i[0], 15'h40c0});
        end
        normal_mode = 1'b0;
        irq(VEC_LAST, 3'h1);
        boundary(5'h0);
        wait_start(VEC_LAST, 1'b1, 1'b1);
        ctrl(SEL_MSTP_A, 8'h00);
        wdt_ovf = 1'b1;
        step;
        wdt_ovf = 1'b0;
        reset_vals;
        wait_start(VEC_RESET, 1'b0, 1'b0);
        ctrl(SEL_INTM, 8'h02);
        ctrl(SEL_CCR, 8'h00);
        // reset must bite without waiting for a clock edge
        rstn = 1'b0;
        #1;
        reset_vals;
        repeat (20) step;
        rstn = 1'b1;
        wait_start(VEC_RESET, 1'b0, 1'b0);
        print_verdict;
    end

    // whole sequence needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge clk_sys);
        error_cnt++;
        print_verdict;
    end
endmodule
